// File: rtl/output_clock_post_divider.sv
/*
 * Output clock post divider: medium divider with phase adjust, low-speed
 * divider with duty shaping, start/stop glitchless except the release when can_stop drops, and pin routing.
 * Assumes core_clk is the half-period tick of the selected fast divider,
 * all inputs are synchronous to it, and pads resolve level and oe_n.
 */
// Added by the designer: the strobed register port.
module output_clock_post_divider
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // Register port
    input  wire logic [11:0]          reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output      logic [7:0]           reg_rdata,
    // Halt and phase adjust sources
    input  wire logic [3:0]           gpio,
    input  wire logic                 adjust_flag_a,
    input  wire logic                 adjust_done_latched,
    input  wire logic                 phase_adjust_event,
    // Output pins
    output      clk_post_pkg::pin_t   out_pos_pin,
    output      clk_post_pkg::pin_t   out_neg_pin
);

    // ************************************************
    // Registers
    // ************************************************
    logic [7:0]  cfg1;
    logic [7:0]  cfg2;
    logic [7:0]  cfg3;
    logic [7:0]  low_div_byte0;
    logic [7:0]  low_div_byte1;
    logic [7:0]  low_div_byte2;
    logic [7:0]  pulse_width;
    logic [7:0]  phase_offset_reg;
    logic [7:0]  halt_control;

    wire logic sel_cfg1  = reg_addr == clk_post_pkg::CFG1_ADDR;
    wire logic sel_cfg2  = reg_addr == clk_post_pkg::CFG2_ADDR;
    wire logic sel_cfg3  = reg_addr == clk_post_pkg::CFG3_ADDR;
    wire logic sel_div0  = reg_addr == clk_post_pkg::LOW_DIV0_ADDR;
    wire logic sel_div1  = reg_addr == clk_post_pkg::LOW_DIV1_ADDR;
    wire logic sel_div2  = reg_addr == clk_post_pkg::LOW_DIV2_ADDR;
    wire logic sel_pulse = reg_addr == clk_post_pkg::PULSE_ADDR;
    wire logic sel_phase = reg_addr == clk_post_pkg::PHASE_ADDR;
    wire logic sel_halt  = reg_addr == clk_post_pkg::HALT_ADDR;
    wire logic sel_stat  = reg_addr == clk_post_pkg::STATUS_ADDR;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cfg1             <= clk_post_pkg::REG_RESET;
            cfg2             <= clk_post_pkg::REG_RESET;
            cfg3             <= clk_post_pkg::REG_RESET;
            low_div_byte0    <= clk_post_pkg::REG_RESET;
            low_div_byte1    <= clk_post_pkg::REG_RESET;
            low_div_byte2    <= clk_post_pkg::REG_RESET;
            pulse_width      <= clk_post_pkg::REG_RESET;
            phase_offset_reg <= clk_post_pkg::REG_RESET;
            halt_control     <= clk_post_pkg::REG_RESET;
        end
        else if (reg_wr)
        begin
            if (sel_cfg1)  cfg1             <= reg_wdata;
            if (sel_cfg2)  cfg2             <= reg_wdata;
            if (sel_cfg3)  cfg3             <= reg_wdata;
            if (sel_div0)  low_div_byte0    <= reg_wdata;
            if (sel_div1)  low_div_byte1    <= reg_wdata;
            if (sel_div2)  low_div_byte2    <= reg_wdata;
            if (sel_pulse) pulse_width      <= reg_wdata;
            if (sel_phase) phase_offset_reg <= reg_wdata;
            if (sel_halt)  halt_control     <= reg_wdata;
        end
    end

    // ************************************************
    // Field decode
    // ************************************************
    wire logic [6:0]  mid_div_value        = cfg1[6:0];
    wire logic        phase_join_enable    = cfg1[clk_post_pkg::JOIN_BIT];
    wire logic        path_invert          = cfg2[clk_post_pkg::INVERT_BIT];
    wire logic        tristate_when_halted = cfg2[clk_post_pkg::TRISTATE_BIT];
    wire clk_post_pkg::pin_format_t pin_format_select =
        clk_post_pkg::pin_format_t'(cfg2[2:0]);
    wire logic        neg_pin_slow_route   = cfg3[clk_post_pkg::ROUTE_BIT];
    wire logic        slow_output_select   = cfg3[clk_post_pkg::SLOW_SEL_BIT];
    wire logic [24:0] slow_div_value       =
        {cfg3[clk_post_pkg::SLOW_TOP_BIT], low_div_byte2,
         low_div_byte1, low_div_byte0};
    wire logic [7:0]  pulse_width_count    = pulse_width;
    wire logic [7:0]  phase_offset         = phase_offset_reg;
    wire logic        soft_halt            =
        halt_control[clk_post_pkg::SOFT_HALT_BIT];
    wire logic [3:0]  halt_source_select   =
        halt_control[clk_post_pkg::SRC_LSB +: 4];
    wire clk_post_pkg::halt_mode_t halt_mode =
        clk_post_pkg::halt_mode_t'(halt_control[clk_post_pkg::MODE_LSB +: 2]);
    wire logic        bypass               = mid_div_value == 7'h00;

    // ************************************************
    // Medium divider with phase adjust
    // ************************************************
    logic       fast_q;
    logic [8:0] mid_cnt;
    logic [7:0] adj_rem;

    // Period counted in half fast periods, so one step is half a UI
    wire logic [8:0] mid_period = {1'b0, mid_div_value, 1'b0} + 9'h002;
    wire logic [8:0] mid_half   = {2'b00, mid_div_value} + 9'h001;
    wire logic       adj_delay  = !adj_rem[7] && adj_rem != 8'h00;
    wire logic       adj_adv    = adj_rem[7];
    wire logic [9:0] mid_step   = adj_adv ? 10'h002 :
                                  (adj_delay ? 10'h000 : 10'h001);
    wire logic [9:0] mid_sum    = {1'b0, mid_cnt} + mid_step;
    wire logic       mid_tick   = !bypass && mid_sum >= {1'b0, mid_period};
    wire logic [9:0] mid_wrap   = mid_sum - {1'b0, mid_period};
    wire logic [8:0] next_mid_cnt = bypass ? 9'h000 :
                                    (mid_tick ? mid_wrap[8:0] : mid_sum[8:0]);
    wire logic       mid_clk    = !bypass && mid_cnt < mid_half;
    wire logic       adj_load   = phase_adjust_event && phase_join_enable
                                  && !bypass;
    // Steps toward zero; a skip of two counts advances by one half UI
    wire logic [7:0] next_adj_rem =
        adj_load  ? phase_offset :
        adj_adv   ? adj_rem + 8'h01 :
        adj_delay ? adj_rem - 8'h01 : adj_rem;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            fast_q  <= 1'b0;
            mid_cnt <= 9'h000;
            adj_rem <= 8'h00;
        end
        else
        begin
            fast_q  <= !fast_q;
            mid_cnt <= next_mid_cnt;
            adj_rem <= next_adj_rem;
        end
    end

    // ************************************************
    // Slow divider and duty shaping
    // ************************************************
    logic [24:0] slow_cnt;

    wire logic [25:0] slow_plus  = {1'b0, slow_div_value} + 26'h000_0001;
    wire logic [24:0] slow_half  = slow_plus[25:1];
    wire logic        duty_on    = !bypass && slow_div_value > 25'h000_0001
                                   && pulse_width_count != 8'h00;
    wire logic [24:0] next_slow_cnt =
        bypass ? 25'h000_0000 :
        !mid_tick ? slow_cnt :
        (slow_cnt >= slow_div_value) ? 25'h000_0000 :
        slow_cnt + 25'h000_0001;
    wire logic        slow_raw =
        bypass ? 1'b0 :
        (slow_div_value == 25'h000_0000) ? mid_clk :
        duty_on ? slow_cnt < {17'h0_0000, pulse_width_count} :
        slow_cnt < slow_half;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            slow_cnt <= 25'h000_0000;
        else
            slow_cnt <= next_slow_cnt;
    end

    // ************************************************
    // Start/stop
    // ************************************************
    logic                      src_prev;
    logic                      arm_stop;
    logic                      stop_level;
    clk_post_pkg::stop_state_t stop_state;
    clk_post_pkg::stop_state_t next_stop_state;

    wire logic src_clk = slow_output_select ? slow_raw : mid_clk;
    wire logic rose    = src_clk && !src_prev;
    wire logic fell    = !src_clk && src_prev;
    wire logic halt_req =
        (halt_source_select == clk_post_pkg::SRC_SOFT)  ? soft_halt :
        (halt_source_select == clk_post_pkg::SRC_ARM)   ? arm_stop :
        (halt_source_select == clk_post_pkg::SRC_GPIO0) ? gpio[0] :
        (halt_source_select == clk_post_pkg::SRC_GPIO1) ? gpio[1] :
        (halt_source_select == clk_post_pkg::SRC_GPIO2) ? gpio[2] :
        (halt_source_select == clk_post_pkg::SRC_GPIO3) ? gpio[3] : 1'b0;
    wire logic stop_hi  = halt_mode == clk_post_pkg::MODE_HIGH;
    wire logic stop_lo  = halt_mode == clk_post_pkg::MODE_LOW;
    wire logic can_stop = !bypass && (stop_hi || stop_lo);
    wire logic halted   = stop_state == clk_post_pkg::HALTED;

    // Decisions ride on source edges so the pin sees no runt, except the release when can_stop drops
    always_comb
    begin
        next_stop_state = stop_state;
        unique case (stop_state)
            clk_post_pkg::RUNNING:
                if (can_stop && halt_req && ((stop_hi && rose) ||
                                             (stop_lo && fell)))
                    next_stop_state = clk_post_pkg::HALTED;
            clk_post_pkg::HALTED:
                if (!can_stop || (!halt_req && ((stop_level && fell) ||
                                                (!stop_level && rose))))
                    next_stop_state = clk_post_pkg::RUNNING;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            src_prev   <= 1'b0;
            arm_stop   <= 1'b0;
            stop_level <= 1'b0;
            stop_state <= clk_post_pkg::RUNNING;
        end
        else
        begin
            src_prev   <= src_clk;
            // Done flag releases and wins over adjust_flag_a flag, which arms the stop
            arm_stop   <= adjust_done_latched ? 1'b0 :
                          (adjust_flag_a ? 1'b1 : arm_stop);
            stop_level <= halted ? stop_level : stop_hi;
            stop_state <= next_stop_state;
        end
    end

    // ************************************************
    // Pin routing
    // ************************************************
    clk_post_pkg::pin_t next_pos;
    clk_post_pkg::pin_t next_neg;

    // Inversion after the hold swaps stop high and stop low
    wire logic gated  = (halted ? stop_level : src_clk) ^ path_invert;
    wire logic float  = halted && tristate_when_halted;
    wire logic off    = pin_format_select == clk_post_pkg::FMT_OFF;
    wire logic pos_en = !off &&
        pin_format_select != clk_post_pkg::FMT_CMOS_NEG;
    wire logic neg_en = !off &&
        pin_format_select != clk_post_pkg::FMT_CMOS_POS;
    // Pin carrying the stop level as set; its partner is the complement, or the same level in FMT_CMOS_INP
    wire logic neg_marks =
        pin_format_select == clk_post_pkg::FMT_HSTL ||
        pin_format_select == clk_post_pkg::FMT_CMOS_NEG ||
        pin_format_select == clk_post_pkg::FMT_CMOS_INV;
    wire logic both_mark =
        pin_format_select == clk_post_pkg::FMT_CMOS_INP;
    wire logic pos_lvl = bypass ? fast_q :
        (both_mark || !neg_marks) ? gated : !gated;
    wire logic neg_lvl = bypass ? (both_mark ? fast_q : !fast_q) :
        (both_mark || neg_marks) ? gated : !gated;

    always_comb
    begin
        next_pos.level = pos_lvl;
        next_pos.oe_n  = !pos_en;
        next_neg.level = neg_lvl;
        next_neg.oe_n  = !neg_en;
        if (float)
        begin
            next_pos.oe_n = 1'b1;
            next_neg.oe_n = 1'b1;
        end
        else if (neg_pin_slow_route && !bypass && !off)
        begin
            next_neg.level = slow_raw;
            next_neg.oe_n  = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            out_pos_pin <= clk_post_pkg::PIN_RESET;
            out_neg_pin <= clk_post_pkg::PIN_RESET;
        end
        else
        begin
            out_pos_pin <= next_pos;
            out_neg_pin <= next_neg;
        end
    end

    // ************************************************
    // Read port
    // ************************************************
    wire logic [7:0] status = {4'h0, out_neg_pin.level, out_pos_pin.level,
                               arm_stop, halted};
    wire logic [7:0] next_rdata =
        sel_cfg1  ? cfg1 :
        sel_cfg2  ? cfg2 :
        sel_cfg3  ? cfg3 :
        sel_div0  ? low_div_byte0 :
        sel_div1  ? low_div_byte1 :
        sel_div2  ? low_div_byte2 :
        sel_pulse ? pulse_width :
        sel_phase ? phase_offset_reg :
        sel_halt  ? halt_control :
        sel_stat  ? status : clk_post_pkg::UNMAPPED_READ;

    always_ff @(posedge core_clk)
    begin
        if (rst)
            reg_rdata <= clk_post_pkg::REG_RESET;
        else if (reg_rd)
            reg_rdata <= next_rdata;
        else
            reg_rdata <= clk_post_pkg::REG_RESET;
    end

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    AST_SLOW_QUIET: assert property (
        bypass |-> !slow_raw)
        else $error("slow divider active with zero medium value");

    AST_PULSE_EDGE: assert property (
        duty_on && mid_tick && slow_cnt == 25'h000_0000 && !reg_wr |=>
        slow_raw == (pulse_width_count != 8'h01))
        else $error("pulse width wrong after first medium period");

    AST_PHASE_IGNORED: assert property (
        phase_adjust_event && !phase_join_enable && adj_rem == 8'h00 |=>
        adj_rem == 8'h00)
        else $error("phase offset applied while joining disabled");

    AST_PHASE_LOAD: assert property (
        adj_load |=> adj_rem == $past(phase_offset))
        else $error("phase offset not loaded on event");

    AST_DELAY_HOLD: assert property (
        adj_delay && !bypass && !reg_wr |=> mid_cnt == $past(mid_cnt))
        else $error("positive offset did not hold the medium count");

    AST_SOFT_HALT: assert property (
        !halted && can_stop && halt_req && stop_hi && rose &&
        halt_source_select == clk_post_pkg::SRC_SOFT |=> halted)
        else $error("software halt not taken on rising edge");

    AST_NEVER_STOP: assert property (
        halt_mode == clk_post_pkg::MODE_NEVER && !reg_wr |=> !halted)
        else $error("clock stopped in never-stop mode");

    AST_HOLD_LEVEL: assert property (
        halted && !reg_wr ##1 halted && !reg_wr |-> $stable(gated))
        else $error("held level moved while stopped");

    AST_FLOAT: assert property (
        halted && tristate_when_halted |=> out_pos_pin.oe_n &&
        out_neg_pin.oe_n)
        else $error("pins driven while stopped with tristate set");

    AST_NEG_ROUTE: assert property (
        !float && neg_pin_slow_route && !bypass && !off |=>
        !out_neg_pin.oe_n && out_neg_pin.level == $past(slow_raw))
        else $error("negative pin not carrying slow divider");

    AST_BYPASS: assert property (
        bypass |=> out_pos_pin.level == $past(fast_q))
        else $error("fast clock not passed in bypass");

    COV_STOP_HIGH: cover property (stop_hi && halted ##1 !halted);
    COV_STOP_LOW:  cover property (stop_lo && halted ##1 !halted);
    COV_ADVANCE:   cover property (adj_adv ##1 adj_rem == 8'h00);
    COV_DUTY:      cover property (duty_on && slow_output_select && mid_tick);

endmodule // output_clock_post_divider

// File: inc/clk_post_pkg.sv
/*
 * Constants, types and register map of the output clock post divider.
 * Assumes an 8-bit register port with 12-bit addresses and a core clock
 * that stands in for the half period of the selected fast divider.
 */
package clk_post_pkg;

    // ************************************************
    // Register offsets
    // ************************************************
    localparam logic [11:0] CFG1_ADDR       = 12'h0200;
    localparam logic [11:0] CFG2_ADDR       = 12'h0201;
    localparam logic [11:0] CFG3_ADDR       = 12'h0202;
    localparam logic [11:0] LOW_DIV0_ADDR   = 12'h0203;
    localparam logic [11:0] LOW_DIV1_ADDR   = 12'h0204;
    localparam logic [11:0] LOW_DIV2_ADDR   = 12'h0205;
    localparam logic [11:0] PULSE_ADDR      = 12'h0206;
    localparam logic [11:0] PHASE_ADDR      = 12'h0207;
    localparam logic [11:0] HALT_ADDR       = 12'h0208;
    localparam logic [11:0] STATUS_ADDR     = 12'h0209;

    localparam logic [7:0]  REG_RESET       = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

    // ************************************************
    // Field positions
    // ************************************************
    localparam int JOIN_BIT      = 7;
    localparam int INVERT_BIT    = 6;
    localparam int TRISTATE_BIT  = 3;
    localparam int ROUTE_BIT     = 5;
    localparam int SLOW_SEL_BIT  = 4;
    localparam int SLOW_TOP_BIT  = 0;
    localparam int SOFT_HALT_BIT = 7;
    localparam int SRC_LSB       = 2;
    localparam int MODE_LSB      = 0;

    // ************************************************
    // Halt sources
    // ************************************************
    localparam logic [3:0] SRC_SOFT  = 4'h0;
    localparam logic [3:0] SRC_ARM   = 4'h1;
    localparam logic [3:0] SRC_GPIO0 = 4'h8;
    localparam logic [3:0] SRC_GPIO1 = 4'h9;
    localparam logic [3:0] SRC_GPIO2 = 4'hA;
    localparam logic [3:0] SRC_GPIO3 = 4'hB;

    typedef enum logic [1:0] {
        MODE_NEVER  = 2'b00,
        MODE_HIGH   = 2'b01,
        MODE_LOW    = 2'b10,
        MODE_UNUSED = 2'b11
    } halt_mode_t;

    typedef enum logic [2:0] {
        FMT_OFF      = 3'b000,
        FMT_CML_STD  = 3'b001,
        FMT_CML_NAR  = 3'b010,
        FMT_HSTL     = 3'b011,
        FMT_CMOS_INP = 3'b100,
        FMT_CMOS_NEG = 3'b101,
        FMT_CMOS_POS = 3'b110,
        FMT_CMOS_INV = 3'b111
    } pin_format_t;

    typedef enum logic {
        RUNNING = 1'b0,
        HALTED  = 1'b1
    } stop_state_t;

    // One output pin: level and active-low enable
    typedef struct packed {
        logic level;
        logic oe_n;
    } pin_t;

    localparam pin_t PIN_RESET = '{level: 1'b0, oe_n: 1'b1};

endpackage

// File: verification/testbench.sv
/*
 * Self-checking bench for the output clock post divider: register access,
 * divider periods, duty shaping, halt sources and modes, pin routing.
 * Assumes the register port of the design and pins sampled on falling edges.
 */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************
    // Signals
    // ************************************************
    logic               core_clk  = 1'b0;
    logic               rst       = 1'b1;
    logic [11:0]        reg_addr  = 12'h0000;
    logic [7:0]         reg_wdata = 8'h00;
    logic               reg_wr    = 1'b0;
    logic               reg_rd    = 1'b0;
    logic [7:0]         reg_rdata;
    logic [3:0]         gpio      = 4'h0;
    logic               adj_flag  = 1'b0;
    logic               adj_done  = 1'b0;
    logic               adj_event = 1'b0;
    clk_post_pkg::pin_t out_pos_pin;
    clk_post_pkg::pin_t out_neg_pin;
    int                 failures        = 0;
    int                 samples_checked = 0;
    int                 cycles          = 0;

    output_clock_post_divider dut
    (
        .core_clk            (core_clk),
        .rst                 (rst),
        .reg_addr            (reg_addr),
        .reg_wdata           (reg_wdata),
        .reg_wr              (reg_wr),
        .reg_rd              (reg_rd),
        .reg_rdata           (reg_rdata),
        .gpio                (gpio),
        .adjust_flag_a       (adj_flag),
        .adjust_done_latched (adj_done),
        .phase_adjust_event  (adj_event),
        .out_pos_pin         (out_pos_pin),
        .out_neg_pin         (out_neg_pin)
    );

    always #12.5 core_clk = ~core_clk;

    // ************************************************
    // Tasks
    // ************************************************
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check_reg(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_pins(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: pin %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic check_delay(input logic [15:0] got,
                               input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: delay %0d expected %0d",
                     $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        @(negedge core_clk);
        check_reg(reg_rdata, exp);
    endtask

    // Settle, then count high samples and level changes over n cycles
    task automatic pins(input bit neg, input int n,
                        input logic [15:0] exp_h, input logic [15:0] exp_t);
        logic        lvl;
        logic        prev;
        logic [15:0] highs;
        logic [15:0] toggles;
        highs   = 16'h0000;
        toggles = 16'h0000;
        repeat (40) @(posedge core_clk);
        @(negedge core_clk);
        prev = neg ? out_neg_pin.level : out_pos_pin.level;
        repeat (n)
        begin
            @(negedge core_clk);
            lvl = neg ? out_neg_pin.level : out_pos_pin.level;
            if (lvl === 1'b1) highs++;
            if (lvl !== prev) toggles++;
            prev = lvl;
        end
        check_pins(highs, exp_h);
        check_pins(toggles, exp_t);
    endtask

    // Cycles from an adjust event to the next falling edge of the pin
    task automatic phase(input logic [7:0] ofs, input logic [15:0] exp);
        logic [15:0] n;
        logic        seen;
        n    = 16'd0;
        seen = 1'b0;
        wr(12'h0207, ofs);
        @(negedge core_clk);
        while (out_pos_pin.level !== 1'b0) @(negedge core_clk);
        while (out_pos_pin.level !== 1'b1) @(negedge core_clk);
        @(posedge core_clk);
        adj_event <= 1'b1;
        @(posedge core_clk);
        adj_event <= 1'b0;
        @(negedge core_clk);
        while (!seen || out_pos_pin.level !== 1'b0)
        begin
            if (out_pos_pin.level === 1'b1) seen = 1'b1;
            n++;
            @(negedge core_clk);
        end
        check_delay(n, exp);
    endtask

    // ************************************************
    // Timeout and main sequence
    // ************************************************
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            failures++;
            results();
        end
    end

    initial
    begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        for (int a = 12'h200; a <= 12'h208; a++)
            rd(12'(a), 8'h00);
        rd(12'h0300, 8'h00);
        for (int a = 12'h203; a <= 12'h208; a++)
        begin
            wr(12'(a), 8'hA5);
            rd(12'(a), 8'hA5);
            wr(12'(a), 8'h00);
        end
        // Bypass: fast clock straight out
        wr(12'h0201, 8'h06);
        pins(0, 100, 16'd50, 16'd100);
        // Medium 4 cycles, slow divide by 3: 12-cycle output
        wr(12'h0200, 8'h01);
        wr(12'h0203, 8'h02);
        wr(12'h0202, 8'h10);
        pins(0, 120, 16'd40, 16'd20);
        // Duty shaping needs slow value above 1: 14-cycle medium, 42-cycle out
        wr(12'h0200, 8'h06);
        wr(12'h0206, 8'h02);
        pins(0, 126, 16'd84, 16'd6);
        wr(12'h0201, 8'h46);
        pins(0, 126, 16'd42, 16'd6);
        wr(12'h0201, 8'h06);
        wr(12'h0206, 8'h00);
        wr(12'h0200, 8'h01);
        // Software halt, stop high
        wr(12'h0208, 8'h81);
        pins(0, 24, 16'd24, 16'd0);
        wr(12'h0201, 8'h0E);
        // Pins are registered: the float shows one edge after the write
        @(posedge core_clk);
        @(negedge core_clk);
        check_pins({14'h0, out_pos_pin.oe_n, out_neg_pin.oe_n}, 16'd3);
        // Differential format marks the negative pin; inversion swaps it
        wr(12'h0201, 8'h03);
        pins(1, 24, 16'd24, 16'd0);
        pins(0, 24, 16'd0, 16'd0);
        wr(12'h0201, 8'h43);
        pins(1, 24, 16'd0, 16'd0);
        wr(12'h0201, 8'h06);
        wr(12'h0208, 8'h01);
        pins(0, 120, 16'd40, 16'd20);
        // Pin halt, stop low; then never-stop mode ignores it
        wr(12'h0208, 8'h22);
        gpio <= 4'h1;
        pins(0, 24, 16'd0, 16'd0);
        wr(12'h0208, 8'h20);
        pins(0, 120, 16'd40, 16'd20);
        gpio <= 4'h0;
        // Adjust_flag_a flag stops high, done flag restarts
        wr(12'h0208, 8'h05);
        adj_flag <= 1'b1;
        @(posedge core_clk);
        adj_flag <= 1'b0;
        pins(0, 24, 16'd24, 16'd0);
        rd(12'h0209, 8'h07);
        adj_done <= 1'b1;
        @(posedge core_clk);
        adj_done <= 1'b0;
        pins(0, 120, 16'd40, 16'd20);
        // Slow divider routed to negative pin, positive keeps medium clock
        wr(12'h0208, 8'h00);
        wr(12'h0201, 8'h04);
        wr(12'h0202, 8'h20);
        pins(1, 120, 16'd40, 16'd20);
        pins(0, 120, 16'd60, 16'd60);
        // Medium period 4: fall 4 cycles after event, shifted by offset
        phase(8'h03, 16'd4);
        wr(12'h0200, 8'h81);
        phase(8'h03, 16'd7);
        phase(8'hFF, 16'd3);
        results();
    end

endmodule // testbench
